// ### src/shadow_bank.sv
// Purpose: Buffer and active copies of every buffered configuration register
// Assumes: Write and update are one-cycle strobes from the register front end
// Notes:   Both images come straight from flip-flops

`default_nettype none

module shadow_bank
    import sync_update_pkg::*;
(
    input  wire logic clk,      // System clock
    input  wire logic reset_n,  // Async reset, active low
    shadow_if.bank    sh        // Write / update / image carrier
);
    shadow_bank_t buffer_q;
    shadow_bank_t buffer_d;
    shadow_bank_t active_q;
    shadow_bank_t active_d;

    always_comb
    begin
        buffer_d = buffer_q;
        active_d = active_q;
        if (sh.wr)
        begin
            buffer_d[sh.idx] = sh.wdata & SYSTEM_MASK;
        end
        // One step for all entries; a write in the same cycle lands next update
        if (sh.update)
        begin
            active_d = buffer_q;  // [RL8]
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            buffer_q <= {NUM_SHADOW{SYSTEM_RESET}};
            active_q <= {NUM_SHADOW{SYSTEM_RESET}};
        end
        else
        begin
            buffer_q <= buffer_d;
            active_q <= active_d;
        end
    end

    assign sh.buffer = buffer_q;
    assign sh.active = active_q;
endmodule

`default_nettype wire

// ### src/shadow_if.sv
// Purpose: Carrier between register front end and buffered register bank
// Assumes: Single clock, all strobes one cycle wide
// Notes:   ctrl drives writes and update, bank returns buffer and active images

`default_nettype none

interface shadow_if;
    import sync_update_pkg::*;

    logic                  wr;
    logic [SHADOW_W-1:0]   idx;
    logic [REG_W-1:0]      wdata;
    logic                  update;
    shadow_bank_t          buffer;
    shadow_bank_t          active;

    modport ctrl (output wr, output idx, output wdata, output update, input buffer, input active);
    modport bank (input wr, input idx, input wdata, input update, output buffer, output active);
endinterface

`default_nettype wire

// ### src/sync_power_update_control.sv
// Purpose: System control bits: sync power-down, distribution reference
//          power-down, soft sync and the update-all strobe
// Assumes: Wishbone classic slave; sync pin is synchronous to clk
// Notes:   Control outputs follow the active image, never the buffer
//
// Local design decision: the Wishbone register port.

`default_nettype none

// Function
// [RL1] Active bit 2 of system register powers down sync circuitry; zero runs normally.
// [RL2] Active bit 1 powers down distribution reference; zero runs normally.
// [RL3] Soft sync bit behaves as the sync pin with inverted polarity.
// [RL4] While soft sync is one, selected channels are held in static state.
// [RL5] A one-to-zero change of soft sync starts a channel synchronization.
// [RL6] Writing one to bit 0 of the update register copies buffers to active.
// [RL7] Update bit clears itself; software never writes it back to zero.
// [RL8] Buffered writes have no effect until update; all copy in one step.
module sync_power_update_control
    import sync_update_pkg::*;
(
    input  wire logic                clk,          // System clock, 50 MHz
    input  wire logic                reset_n,      // Async reset, active low
    input  wire logic                wb_cyc_i,     // Bus cycle
    input  wire logic                wb_stb_i,     // Bus strobe
    input  wire logic                wb_we_i,      // Write enable
    input  wire logic [ADR_W-1:0]    wb_adr_i,     // Byte address
    input  wire logic [SEL_W-1:0]    wb_sel_i,     // Byte lane selects
    input  wire logic [DAT_W-1:0]    wb_dat_i,     // Write data
    output var  logic [DAT_W-1:0]    wb_dat_o,     // Read data, registered
    output var  logic                wb_ack_o,     // Acknowledge, registered
    input  wire logic                sync_n_pin,   // External sync, active low
    output var  logic                sync_pd,      // Sync circuitry power-down
    output var  logic                dist_ref_pd,  // Distribution reference power-down
    output var  logic                sync_hold,    // Hold selected channels static
    output var  logic                sync_start    // One-cycle sync trigger
);
    import sync_update_pkg::*;

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    shadow_if sh ();

    logic             ack_q;
    logic             ack_d;
    logic [DAT_W-1:0] rdat_q;
    logic [DAT_W-1:0] rdat_d;
    logic [IDX_W-1:0] idx;
    logic             req;
    logic             wr_now;
    logic [REG_W-1:0] sys_buf;
    logic [REG_W-1:0] sys_act;
    sync_state_t      state_q;
    sync_state_t      state_d;
    logic             start_q;
    logic             start_d;

    assign idx     = reg_index(wb_adr_i);
    assign req     = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign wr_now  = req & wb_we_i & ack_q & wb_sel_i[0];
    assign sys_buf = sh.buffer[SHADOW_SYSTEM];
    assign sys_act = sh.active[SHADOW_SYSTEM];

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic hit_system;
    logic hit_update;

    // Address bits 1:0 are ignored, so any byte of a word selects it
    assign hit_system = (idx == IDX_SYSTEM);
    assign hit_update = (idx == IDX_UPDATE);

    // ----------------------------------------------------------------
    // Status image
    // ----------------------------------------------------------------
    logic [REG_W-1:0] status_img;

    // Live view of what the outputs follow, unlike the buffered read
    always_comb
    begin
        status_img                    = '0;
        status_img[BIT_STAT_ACT_HI:0] = sys_act[BIT_STAT_ACT_HI:0];
        status_img[BIT_STAT_HOLD]     = (state_q == SYNC_HOLD);
        status_img[BIT_STAT_PIN]      = sync_n_pin;
    end

    // ----------------------------------------------------------------
    // Bank access
    // ----------------------------------------------------------------
    assign sh.wr     = wr_now & hit_system;
    assign sh.idx    = SHADOW_SYSTEM;
    assign sh.wdata  = wb_dat_i[REG_W-1:0];
    // Strobe lasts one cycle and is not stored; the update register always reads back as zero
    assign sh.update = wr_now & hit_update & wb_dat_i[BIT_UPDATE];  // [RL6] [RL7]

    always_comb
    begin
        // One wait state per access; ack falls after one cycle even if stb stays
        ack_d  = req & ~ack_q;
        rdat_d = rdat_q;
        if (req & ~ack_q)
        begin
            rdat_d = DATA_ZERO;
            unique case (idx)
                IDX_SYSTEM:
                begin
                    rdat_d[REG_W-1:0] = sys_buf;
                end
                IDX_STATUS:
                begin
                    rdat_d[REG_W-1:0] = status_img;
                end
                default:
                begin
                    // Update register and unmapped words read zero
                    rdat_d = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q  <= 1'b0;
            rdat_q <= DATA_ZERO;
        end
        else
        begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ----------------------------------------------------------------
    // Bus outputs
    // ----------------------------------------------------------------
    // Both come straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ----------------------------------------------------------------
    // Buffered / active register bank
    // ----------------------------------------------------------------
    // Holds buffer and active copies; only the system register is buffered
    shadow_bank u_bank
    (
        .clk     (clk),
        .reset_n (reset_n),
        .sh      (sh.bank)
    );

    // ----------------------------------------------------------------
    // Power-down outputs
    // ----------------------------------------------------------------
    // Taken from the active image so buffered writes change nothing yet
    assign sync_pd     = sys_act[BIT_PD_SYNC];      // [RL1]
    assign dist_ref_pd = sys_act[BIT_PD_DIST_REF];  // [RL2]

    // ----------------------------------------------------------------
    // Sync sequencer
    // ----------------------------------------------------------------
    logic sync_low;

    // Pin is taken as synchronous to clk; an async source needs a synchroniser
    // Soft sync one is the pin held low; either source asserts sync
    assign sync_low = ~sync_n_pin | sys_act[BIT_SOFT_SYNC];  // [RL3]

    always_comb
    begin
        state_d = state_q;
        start_d = 1'b0;
        // Powered-down sync logic neither holds nor triggers
        if (sys_act[BIT_PD_SYNC])  // [RL1]
        begin
            state_d = SYNC_RUN;
        end
        else
        begin
            unique case (state_q)
                SYNC_RUN:
                begin
                    if (sync_low)
                    begin
                        state_d = SYNC_HOLD;  // [RL4]
                    end
                end
                SYNC_HOLD:
                begin
                    if (!sync_low)
                    begin
                        state_d = SYNC_RUN;
                        start_d = 1'b1;  // [RL5]
                    end
                end
                default:
                begin
                    // Illegal one-hot code falls back to run
                    state_d = SYNC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= SYNC_RUN;
            start_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            start_q <= start_d;
        end
    end

    assign sync_hold  = (state_q == SYNC_HOLD);  // [RL4]
    assign sync_start = start_q;

endmodule

`default_nettype wire

// ### src/sync_update_pkg.sv
// Purpose: Shared constants and types for the sync / power / update register block
// Assumes: Wishbone classic slave with 32-bit data, 4-byte word per register
// Notes:   Register byte address is four times the register index

`default_nettype none

package sync_update_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int REG_W = 8;
    localparam int IDX_W = 10;

    // ----------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_SYSTEM = 10'h230;
    localparam logic [IDX_W-1:0] IDX_UPDATE = 10'h232;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h234;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_PD_SYNC     = 2;
    localparam int BIT_PD_DIST_REF = 1;
    localparam int BIT_SOFT_SYNC   = 0;
    localparam int BIT_UPDATE      = 0;
    localparam int BIT_STAT_HOLD   = 3;
    localparam int BIT_STAT_PIN    = 4;
    localparam int BIT_STAT_ACT_HI = 2;

    localparam logic [REG_W-1:0] SYSTEM_RESET = 8'h00;
    localparam logic [REG_W-1:0] SYSTEM_MASK  = 8'h07;
    localparam logic [DAT_W-1:0] DATA_ZERO    = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Buffered register bank
    // ----------------------------------------------------------------
    localparam int NUM_SHADOW = 1;
    localparam int SHADOW_W   = 1;
    localparam logic [SHADOW_W-1:0] SHADOW_SYSTEM = 1'h0;

    typedef logic [NUM_SHADOW-1:0][REG_W-1:0] shadow_bank_t;

    typedef enum logic [1:0]
    {
        SYNC_RUN  = 2'b01,
        SYNC_HOLD = 2'b10
    } sync_state_t;

    // Word index from a byte address
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADR_W-1:0] adr);
        reg_index = adr[ADR_W-1:2];
    endfunction

endpackage

`default_nettype wire

// ### test/sync_power_update_control_assertions.sv
// Purpose: Properties on the control outputs and read data
// Assumes: One clock, reset_n async active low
// Notes:   Keeps its own copy of the buffered system bits
`default_nettype none
module sync_power_update_control_assertions
    import sync_update_pkg::*;
(
    input wire logic             clk,         // Clock
    input wire logic             reset_n,     // Reset
    input wire logic             wb_cyc_i,    // Cycle
    input wire logic             wb_stb_i,    // Strobe
    input wire logic             wb_we_i,     // Write
    input wire logic [ADR_W-1:0] wb_adr_i,    // Address
    input wire logic [SEL_W-1:0] wb_sel_i,    // Lanes
    input wire logic [DAT_W-1:0] wb_dat_i,    // Write data
    input wire logic [DAT_W-1:0] wb_dat_o,    // Read data
    input wire logic             wb_ack_o,    // Ack
    input wire logic             sync_n_pin,  // Pin
    input wire logic             sync_pd,     // Sync off
    input wire logic             dist_ref_pd, // Ref off
    input wire logic             sync_hold,   // Hold
    input wire logic             sync_start   // Start
);
    // ------------------------------------------------------------
    // Buffer shadow
    // ------------------------------------------------------------
    logic [2:0] buf_q;
    logic [2:0] buf_d;
    logic       wr;
    logic       upd;
    assign wr  = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign upd = wr & wb_dat_i[0] & (wb_adr_i[11:2] == IDX_UPDATE);
    always_comb
    begin
        buf_d = buf_q;
        if (wr && wb_adr_i[11:2] == IDX_SYSTEM)
            buf_d = wb_dat_i[2:0];
    end
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            buf_q <= 3'h0;
        else
            buf_q <= buf_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_upd;
        upd |=> sync_pd == buf_q[2] && dist_ref_pd == buf_q[1];
    endproperty
    a_upd: assert property (p_upd) else $error("pd not copied");
    property p_held;
        !$past(upd) |-> $stable(sync_pd) && $stable(dist_ref_pd);
    endproperty
    a_held: assert property (p_held) else $error("pd moved early");
    property p_pin;
        !sync_n_pin && !sync_pd |=> sync_hold;
    endproperty
    a_pin: assert property (p_pin) else $error("no hold");
    property p_pd;
        sync_pd |=> !sync_hold && !sync_start;
    endproperty
    a_pd: assert property (p_pd) else $error("sync not off");
    property p_rel;
        sync_hold && !sync_pd |=> sync_start != sync_hold;
    endproperty
    a_rel: assert property (p_rel) else $error("bad release");
    property p_start;
        sync_start |-> $past(sync_hold) && !sync_hold ##1 !sync_start;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_rd_upd;
        wb_ack_o && !wb_we_i && wb_adr_i[11:2] == IDX_UPDATE |-> wb_dat_o == DATA_ZERO;
    endproperty
    a_rd_upd: assert property (p_rd_upd) else $error("update bit set");
    property p_rd_sys;
        wb_ack_o && !wb_we_i && wb_adr_i[11:2] == IDX_SYSTEM |-> wb_dat_o == {29'h0, buf_q};
    endproperty
    a_rd_sys: assert property (p_rd_sys) else $error("bad buffer");
endmodule
bind sync_power_update_control sync_power_update_control_assertions u_chk (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_n_pin(sync_n_pin),
    .sync_pd(sync_pd), .dist_ref_pd(dist_ref_pd), .sync_hold(sync_hold), .sync_start(sync_start));
`default_nettype wire

// ### test/sync_power_update_control_tb.sv
// Purpose: Directed register and sync bench
// Assumes: Bus answers one cycle after a request
// Notes:   Output latency is waited out, not counted
`default_nettype none
module sync_power_update_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sync_update_pkg::*;
    localparam logic [ADR_W-1:0] SYS = {IDX_SYSTEM, 2'h0};
    localparam logic [ADR_W-1:0] UPD = {IDX_UPDATE, 2'h0};
    localparam logic [ADR_W-1:0] STA = {IDX_STATUS, 2'h0};
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [ADR_W-1:0] adr = 12'h000;
    logic [SEL_W-1:0] sel = 4'h0;
    logic [DAT_W-1:0] wdat = 32'h0;
    logic             pin_n = 1'b1;
    logic [DAT_W-1:0] rdat;
    logic [DAT_W-1:0] q;
    logic             ack, pd_s, pd_r, hold, start;
    wire  [DAT_W-1:0] outs = {29'h0, pd_s, pd_r, hold};
    int               n_fail = 0;
    int               tests_run = 0;
    int               ns;
    always #10 clk = ~clk;
    sync_power_update_control uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sync_n_pin(pin_n), .sync_pd(pd_s), .dist_ref_pd(pd_r), .sync_hold(hold), .sync_start(start));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic cnt;
        ns = 0;
        repeat (8)
        begin
            @(posedge clk);
            if (start === 1'b1)
                ns++;
        end
    endtask
    task automatic upd(input logic [7:0] v);
        bus(1'b1, SYS, {24'h0, v}, 4'h1);
        bus(1'b1, UPD, 32'h1, 4'h1);
        cnt();
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        cnt();
        chk("out", 32'h0, outs);
        bus(1'b1, SYS, 32'h6, 4'h1);
        cnt();
        chk("out", 32'h0, outs);
        bus(1'b0, SYS, 32'h0, 4'hf);
        chk("sys", 32'h6, q);
        bus(1'b1, UPD, 32'h1, 4'h1);
        cnt();
        chk("out", 32'h6, outs);
        bus(1'b0, UPD, 32'h0, 4'hf);
        chk("upd", 32'h0, q);
        bus(1'b1, SYS, 32'h1, 4'h0);
        bus(1'b0, SYS, 32'h0, 4'hf);
        chk("sel", 32'h6, q);
        upd(8'h01);
        chk("out", 32'h1, outs);
        upd(8'h00);
        chk("start", 32'h1, 32'(ns));
        chk("out", 32'h0, outs);
        @(posedge clk);
        pin_n <= 1'b0;
        cnt();
        chk("pin", 32'h1, outs);
        bus(1'b0, STA, 32'h0, 4'hf);
        chk("stat", 32'h8, q);
        upd(8'h04);
        chk("pd", 32'h4, outs);
        chk("nostart", 32'h0, 32'(ns));
        upd(8'h00);
        @(posedge clk);
        pin_n <= 1'b1;
        cnt();
        chk("pinrel", 32'h1, 32'(ns));
        bus(1'b1, 12'h004, 32'hff, 4'hf);
        bus(1'b0, 12'h004, 32'h0, 4'hf);
        chk("unmapped", 32'h0, q);
        upd(8'h06);
        bus(1'b0, STA, 32'h0, 4'hf);
        chk("stat", 32'h16, q);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        cnt();
        chk("rst", 32'h0, outs);
        bus(1'b0, SYS, 32'h0, 4'hf);
        chk("sysrst", 32'h0, q);
        complete_run();
    end
endmodule
`default_nettype wire
